//--- src/dma_channel_select_busy_wrap.sv
// Channel select, busy/forced start and wrap control of a seven-channel DMA
`timescale 1ns/10ps
`include "dma_sel_params.svh"
module dma_channel_select_busy_wrap
  import dma_sel_pkg::*;
#(
  parameter int NUM_CHAN = `NUM_CHAN
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Special function register bus
  input wire dma_sel_pkg::sfr_byte_t sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire dma_sel_pkg::sfr_byte_t sfr_wdata,
  output dma_sel_pkg::sfr_byte_t sfr_rdata,
  // Byte moved by the transfer datapath, one bit per channel
  input wire dma_sel_pkg::chan_vec_t byte_done,
  // Channel state towards the datapath
  output dma_sel_pkg::chan_vec_t chan_active,
  output dma_sel_pkg::chan_vec_t chan_go,
  output dma_sel_pkg::chan_vec_t full_length_flags,
  output dma_sel_pkg::chan_vec_t mid_point_flags,
  output dma_sel_pkg::chan_vec_t chan_complete
);
  import dma_sel_pkg::*;

  // True for addresses of the per-channel indirect registers
  function automatic logic is_indirect(input sfr_byte_t a);
    is_indirect = (a >= `ADDR_CONFIG) && (a <= `ADDR_SIZE_HI);
  endfunction : is_indirect

  // Direct control registers
  chan_sel_t select_ff; // Channel select pointer
  chan_sel_t nxt_select;
  chan_vec_t enable_ff; // Channel enable bits
  chan_vec_t nxt_enable;
  chan_vec_t busy_ff; // Transfer in progress
  chan_vec_t nxt_busy;
  chan_vec_t full_ff; // Full-length flags
  chan_vec_t nxt_full;
  chan_vec_t mid_ff; // Mid-point flags
  chan_vec_t nxt_mid;
  chan_vec_t go_ff; // Registered step permission
  chan_vec_t nxt_go;
  chan_vec_t complete_ff; // Registered completion pulses
  chan_vec_t nxt_complete;
  sfr_byte_t rdata_ff; // Read data
  sfr_byte_t nxt_rdata;

  // Per-channel registers: indirect ones and the wrap mode bit
  sfr_byte_t config_ff [NUM_CHAN]; // Function configuration
  sfr_byte_t nxt_config [NUM_CHAN];
  base_t base_ff [NUM_CHAN]; // Base address
  base_t nxt_base [NUM_CHAN];
  ofs_t size_ff [NUM_CHAN]; // Transfer length
  ofs_t nxt_size [NUM_CHAN];
  logic wrap_ff [NUM_CHAN]; // Wrap enable
  logic nxt_wrap [NUM_CHAN];

  // Decode and counter wiring
  chan_vec_t sel_onehot; // Selected channel
  logic sel_valid; // Select code names a channel
  chan_vec_t step; // Byte counted this cycle
  chan_vec_t done; // Last byte counted
  chan_vec_t mid_hit; // Mid-point reached
  chan_vec_t ofs_load; // Software offset write
  ofs_t offset [NUM_CHAN]; // Counter values
  ofs_t ofs_load_val [NUM_CHAN]; // Offset write value
  logic wr_direct; // Write to a direct register
  logic wr_ind; // Write reaches a channel copy
  chan_sel_t sel_idx; // Index of the selected channel

  // Select pointer decode
  chan_sel_decode u_sel_decode
  (
    .sel(select_ff),
    .onehot(sel_onehot),
    .valid(sel_valid)
  );

  // Writes to indirect registers land only when a channel is selected
  always_comb
  begin
    wr_direct = sfr_wr && !is_indirect(sfr_addr);
    wr_ind = sfr_wr && is_indirect(sfr_addr) && sel_valid;
    sel_idx = sel_valid ? select_ff : 3'h0;
  end

  // Step permission: busy, enabled and not stalled
  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      step[i] = go_ff[i] && byte_done[i];
      nxt_go[i] = nxt_busy[i] && nxt_enable[i] && !nxt_config[i][`CFG_STALL_BIT];
    end
  end

  // One offset counter per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++)
    begin : g_chan
      // Offset byte writes reach the selected copy only
      // One continuous driver per bit keeps every bit with a single source
      assign ofs_load[g] = wr_ind && sel_onehot[g] &&
                           ((sfr_addr == `ADDR_OFS_LO) || (sfr_addr == `ADDR_OFS_HI));
      assign ofs_load_val[g] = (sfr_addr == `ADDR_OFS_LO) ?
                               {offset[g][15:8], sfr_wdata} : {sfr_wdata, offset[g][7:0]};

      chan_offset_counter u_counter
      (
        .clk(clk),
        .reset_n(reset_n),
        .load(ofs_load[g]),
        .load_val(ofs_load_val[g]),
        .step(step[g]),
        .size(size_ff[g]),
        .wrap(wrap_ff[g]),
        .offset(offset[g]),
        .done(done[g]),
        .mid_hit(mid_hit[g])
      );
    end
  endgenerate

  // Next values of the direct registers
  always_comb
  begin
    nxt_select = select_ff;
    nxt_enable = enable_ff;
    nxt_full = full_ff;
    nxt_mid = mid_ff;
    nxt_busy = busy_ff;
    // Select keeps only bits 2:0
    if (wr_direct && (sfr_addr == `ADDR_SELECT))
    begin
      nxt_select = sfr_wdata[2:0];
    end
    // Enable bits, bit 7 dropped
    if (wr_direct && (sfr_addr == `ADDR_ENABLE))
    begin
      nxt_enable = sfr_wdata[6:0];
    end
    // Flags: software writes zero to clear
    if (wr_direct && (sfr_addr == `ADDR_FULL_FLAG))
    begin
      nxt_full = full_ff & sfr_wdata[6:0];
    end
    if (wr_direct && (sfr_addr == `ADDR_MID_FLAG))
    begin
      nxt_mid = mid_ff & sfr_wdata[6:0];
    end
    // Hardware set wins over a clear in the same cycle
    nxt_full = nxt_full | done;
    nxt_mid = nxt_mid | mid_hit;
    // Busy ends on completion or when the channel is disabled
    nxt_busy = busy_ff & ~done & nxt_enable;
    // Forced start: ones set, zeros ignored, bit 7 dropped
    if (wr_direct && (sfr_addr == `ADDR_BUSY))
    begin
      nxt_busy = nxt_busy | sfr_wdata[6:0];
    end
    nxt_complete = done;
  end

  // Direct registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      select_ff <= 3'h0;
      enable_ff <= 7'h00;
      busy_ff <= 7'h00;
      full_ff <= 7'h00;
      mid_ff <= 7'h00;
      go_ff <= 7'h00;
      complete_ff <= 7'h00;
    end
    else
    begin
      select_ff <= nxt_select;
      enable_ff <= nxt_enable;
      busy_ff <= nxt_busy;
      full_ff <= nxt_full;
      mid_ff <= nxt_mid;
      go_ff <= nxt_go;
      complete_ff <= nxt_complete;
    end
  end

  // Next values of the per-channel copies, written through the pointer
  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      nxt_config[i] = config_ff[i];
      nxt_base[i] = base_ff[i];
      nxt_size[i] = size_ff[i];
      nxt_wrap[i] = wrap_ff[i];
      if (wr_ind && sel_onehot[i])
      begin
        unique case (sfr_addr)
          `ADDR_CONFIG: nxt_config[i] = {sfr_wdata[7:4], 1'b0, sfr_wdata[2:0]};
          `ADDR_BASE_LO: nxt_base[i] = {base_ff[i][11:8], sfr_wdata};
          `ADDR_BASE_HI: nxt_base[i] = {sfr_wdata[3:0], base_ff[i][7:0]};
          `ADDR_SIZE_LO: nxt_size[i] = {size_ff[i][15:8], sfr_wdata};
          `ADDR_SIZE_HI: nxt_size[i] = {sfr_wdata, size_ff[i][7:0]};
          default: nxt_config[i] = config_ff[i]; // Offset bytes go to counter
        endcase
      end
      // Mode register sits among direct addresses but is per channel
      if (wr_direct && (sfr_addr == `ADDR_MODE) && sel_valid && sel_onehot[i])
      begin
        nxt_wrap[i] = sfr_wdata[`MODE_WRAP_BIT];
      end
    end
  end

  // Per-channel copies
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        config_ff[i] <= `RST_BYTE;
        base_ff[i] <= `RST_BASE;
        size_ff[i] <= `RST_OFS;
        wrap_ff[i] <= 1'b0;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        config_ff[i] <= nxt_config[i];
        base_ff[i] <= nxt_base[i];
        size_ff[i] <= nxt_size[i];
        wrap_ff[i] <= nxt_wrap[i];
      end
    end
  end

  // Read data mux, registered on a read strobe
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (sfr_rd)
    begin
      nxt_rdata = `RST_BYTE; // Unmapped reads return zero
      unique case (sfr_addr)
        `ADDR_SELECT: nxt_rdata = {5'h00, select_ff};
        `ADDR_ENABLE: nxt_rdata = {1'b0, enable_ff};
        `ADDR_FULL_FLAG: nxt_rdata = {1'b0, full_ff};
        `ADDR_MID_FLAG: nxt_rdata = {1'b0, mid_ff};
        `ADDR_BUSY: nxt_rdata = {1'b0, busy_ff};
        `ADDR_MODE: nxt_rdata = sel_valid ? {7'h00, wrap_ff[sel_idx]} : `RST_BYTE;
        `ADDR_CONFIG: nxt_rdata = sel_valid ? config_ff[sel_idx] : `RST_BYTE;
        `ADDR_BASE_LO: nxt_rdata = sel_valid ? base_ff[sel_idx][7:0] : `RST_BYTE;
        `ADDR_BASE_HI: nxt_rdata = sel_valid ? {4'h0, base_ff[sel_idx][11:8]} : `RST_BYTE;
        `ADDR_OFS_LO: nxt_rdata = sel_valid ? offset[sel_idx][7:0] : `RST_BYTE;
        `ADDR_OFS_HI: nxt_rdata = sel_valid ? offset[sel_idx][15:8] : `RST_BYTE;
        `ADDR_SIZE_LO: nxt_rdata = sel_valid ? size_ff[sel_idx][7:0] : `RST_BYTE;
        `ADDR_SIZE_HI: nxt_rdata = sel_valid ? size_ff[sel_idx][15:8] : `RST_BYTE;
        default: nxt_rdata = `RST_BYTE;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_ff <= `RST_BYTE;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rdata = rdata_ff;
  assign chan_active = busy_ff;
  assign chan_go = go_ff;
  assign full_length_flags = full_ff;
  assign mid_point_flags = mid_ff;
  assign chan_complete = complete_ff;
endmodule : dma_channel_select_busy_wrap

//--- common/dma_sel_params.svh
// Constants for the channel select, busy and wrap control slice
// Operation
// - Busy bit reads one while channel transfers
// - Writing one to busy forces transfer start
// - Busy zero writes ignored, bit seven zero
// - Select bits 2:0 name channel 0..6
// - Select code 111 is invalid, none selected
// - Indirect registers reach the selected channel copy
// - Wrap mode register kept per channel
// - Offset counts zero up to size minus one
// - Offset at size minus one completes, sets flag
// - Wrap set returns offset to zero at completion
// - Select bits 7:3 read zero, ignore writes
// - Full-length flag sticky until software clears it
// - Channel transfers only while its enable is one
`ifndef DMA_SEL_PARAMS_SVH
`define DMA_SEL_PARAMS_SVH

// Channel count and widths
`define NUM_CHAN 7
`define SEL_W 3
`define OFS_W 16
`define BASE_W 12

// Direct register addresses
`define ADDR_SELECT 8'hd1
`define ADDR_ENABLE 8'hd2
`define ADDR_FULL_FLAG 8'hd3
`define ADDR_MID_FLAG 8'hd4
`define ADDR_BUSY 8'hd5
`define ADDR_MODE 8'hd6

// Indirect register addresses
`define ADDR_CONFIG 8'hc9
`define ADDR_BASE_LO 8'hca
`define ADDR_BASE_HI 8'hcb
`define ADDR_OFS_LO 8'hcc
`define ADDR_OFS_HI 8'hcd
`define ADDR_SIZE_LO 8'hce
`define ADDR_SIZE_HI 8'hcf

// Field positions
`define CFG_STALL_BIT 5
`define MODE_WRAP_BIT 0
`define SEL_INVALID 3'h7

// Reset values
`define RST_BYTE 8'h00
`define RST_OFS 16'h0000
`define RST_BASE 12'h000

`endif

//--- common/dma_sel_pkg.sv
// Types shared by the channel select, busy and wrap slice
package dma_sel_pkg;
  typedef logic [7:0] sfr_byte_t;
  typedef logic [6:0] chan_vec_t;
  typedef logic [2:0] chan_sel_t;
  typedef logic [15:0] ofs_t;
  typedef logic [11:0] base_t;
endpackage : dma_sel_pkg

//--- src/chan_sel_decode.sv
// Channel select code to one-hot channel decoder
`timescale 1ns/10ps
`include "dma_sel_params.svh"
module chan_sel_decode
  import dma_sel_pkg::*;
(
  // Select code
  input wire dma_sel_pkg::chan_sel_t sel,
  // Decoded channel
  output dma_sel_pkg::chan_vec_t onehot,
  output logic valid
);
  // Code 111 names no channel
  always_comb
  begin
    onehot = 7'h00;
    valid = (sel != `SEL_INVALID);
    if (valid)
    begin
      onehot[sel] = 1'b1;
    end
  end
endmodule : chan_sel_decode

//--- src/chan_offset_counter.sv
// One channel's address offset counter with completion and mid-point detect
`timescale 1ns/10ps
`include "dma_sel_params.svh"
module chan_offset_counter
  import dma_sel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Software load of the offset
  input wire logic load,
  input wire dma_sel_pkg::ofs_t load_val,
  // One byte moved on this channel
  input wire logic step,
  // Channel settings
  input wire dma_sel_pkg::ofs_t size,
  input wire logic wrap,
  // Counter state and events
  output dma_sel_pkg::ofs_t offset,
  output logic done,
  output logic mid_hit
);
  ofs_t offset_ff; // Current offset
  ofs_t nxt_offset; // Next offset
  ofs_t last_ofs; // Size minus one
  ofs_t mid_ofs; // Mid-point offset
  ofs_t ofs_plus; // Offset plus one
  logic at_end; // Offset sits at last byte

  // Next offset, completion and mid-point events
  always_comb
  begin
    last_ofs = size - 16'h0001;
    mid_ofs = size[0] ? ((size >> 1) + 16'h0001) : (size >> 1);
    ofs_plus = offset_ff + 16'h0001;
    at_end = (offset_ff == last_ofs);
    done = step && at_end;
    mid_hit = step && !at_end && (ofs_plus == mid_ofs);
    nxt_offset = offset_ff;
    if (load)
    begin
      nxt_offset = load_val; // Software write wins
    end
    else if (done)
    begin
      nxt_offset = wrap ? `RST_OFS : offset_ff;
    end
    else if (step)
    begin
      nxt_offset = ofs_plus;
    end
  end

  // Offset register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      offset_ff <= `RST_OFS;
    end
    else
    begin
      offset_ff <= nxt_offset;
    end
  end

  assign offset = offset_ff;
endmodule : chan_offset_counter

//--- bench/dma_channel_select_busy_wrap_checker.sv
// Port assertions for the channel select, busy and wrap slice
`timescale 1ns/10ps
`include "dma_sel_params.svh"
module dma_channel_select_busy_wrap_checker
  import dma_sel_pkg::*;
#(
  parameter int NUM_CHAN = `NUM_CHAN
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input wire dma_sel_pkg::sfr_byte_t sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire dma_sel_pkg::sfr_byte_t sfr_wdata,
  input wire dma_sel_pkg::sfr_byte_t sfr_rdata,
  // Datapath side
  input wire dma_sel_pkg::chan_vec_t byte_done,
  input wire dma_sel_pkg::chan_vec_t chan_active,
  input wire dma_sel_pkg::chan_vec_t chan_go,
  input wire dma_sel_pkg::chan_vec_t full_length_flags,
  input wire dma_sel_pkg::chan_vec_t mid_point_flags,
  input wire dma_sel_pkg::chan_vec_t chan_complete
);
  // One clock domain, reset disables all checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  busy_top_zero_a: assert property (
    sfr_rd && sfr_addr == `ADDR_BUSY |=> sfr_rdata[7] == 1'b0)
    else $error("busy bit 7 read as one");
  sel_high_zero_a: assert property (
    sfr_rd && sfr_addr == `ADDR_SELECT |=> sfr_rdata[7:3] == 5'h00)
    else $error("select bits 7:3 not zero");
  mode_high_zero_a: assert property (
    sfr_rd && sfr_addr == `ADDR_MODE |=> sfr_rdata[7:1] == 7'h00)
    else $error("mode bits 7:1 not zero");
  zero_write_inert_a: assert property (
    sfr_wr && sfr_addr == `ADDR_BUSY && sfr_wdata == 8'h00
    |=> (chan_active & ~$past(chan_active)) == 7'h00)
    else $error("busy zero write started a channel");
  go_needs_busy_a: assert property (
    (chan_go & ~chan_active) == 7'h00)
    else $error("channel moving while idle");
  done_sets_flag_a: assert property (
    chan_complete != 7'h00 |-> (full_length_flags & chan_complete) == chan_complete)
    else $error("completion without full flag");
  done_goes_idle_a: assert property (
    chan_complete != 7'h00 && !$past(sfr_wr && sfr_addr == `ADDR_BUSY)
    |-> ((chan_active | chan_go) & chan_complete) == 7'h00)
    else $error("busy kept after completion");
  done_one_cycle_a: assert property (
    chan_complete != 7'h00 |=> (chan_complete & $past(chan_complete)) == 7'h00)
    else $error("completion pulse too long");
  flag_sticky_a: assert property (
    ($past(full_length_flags) & ~full_length_flags) != 7'h00
    |-> $past(sfr_wr) && $past(sfr_addr) == `ADDR_FULL_FLAG)
    else $error("full flag cleared without write");
  // Mid-point flags fall only through a software write
  mid_sticky_a: assert property (
    ($past(mid_point_flags) & ~mid_point_flags) != 7'h00
    |-> $past(sfr_wr) && $past(sfr_addr) == `ADDR_MID_FLAG)
    else $error("mid flag cleared without write");
  // A channel turns busy only through a forced start write
  start_by_write_a: assert property (
    (chan_active & ~$past(chan_active)) != 7'h00
    |-> $past(sfr_wr) && $past(sfr_addr) == `ADDR_BUSY)
    else $error("channel busy without forced start");
  // Completion needs a byte counted while permitted
  done_needs_byte_a: assert property (
    chan_complete != 7'h00 |-> ($past(byte_done & chan_go) & chan_complete) == chan_complete)
    else $error("completion without permitted byte");
endmodule : dma_channel_select_busy_wrap_checker

//--- bench/dma_sel_datapath_model.sv
// Datapath stand-in moving one byte per permitted channel after a gap
`timescale 1ns/10ps
module dma_sel_datapath_model
  import dma_sel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Permission and idle cycles between bytes
  input wire dma_sel_pkg::chan_vec_t chan_go,
  input wire logic [3:0] gap,
  // Byte moved pulses
  output dma_sel_pkg::chan_vec_t byte_done
);
  import dma_sel_pkg::*;
  // Wait counters and byte pulses
  logic [3:0] wait_ff [7];
  logic [3:0] nxt_wait [7];
  chan_vec_t done_ff;
  chan_vec_t nxt_done;
  assign byte_done = done_ff;
  // Move a byte only while permitted, then wait
  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      nxt_done[i] = chan_go[i] && wait_ff[i] == 4'h0;
      nxt_wait[i] = nxt_done[i] ? gap : (wait_ff[i] == 4'h0 ? 4'h0 : wait_ff[i] - 4'h1);
    end
  end
  // State registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_ff <= 7'h00;
      wait_ff <= '{default: 4'h0};
    end
    else
    begin
      done_ff <= nxt_done;
      wait_ff <= nxt_wait;
    end
  end
endmodule : dma_sel_datapath_model

//--- bench/dma_channel_select_busy_wrap_tb_top.sv
// Self-checking bench for the channel select, busy and wrap slice
`timescale 1ns/10ps
module dma_channel_select_busy_wrap_tb_top;
  import dma_sel_pkg::*;
  // Bench drive
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  sfr_byte_t sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  sfr_byte_t sfr_wdata = 8'h00;
  logic [3:0] gap = 4'h0;
  // Design outputs
  sfr_byte_t sfr_rdata;
  chan_vec_t byte_done, chan_active, chan_go, full_length_flags, mid_point_flags, chan_complete;
  // Counters
  int n_fail = 0;
  int tests_run = 0;
  // 100 ns clock
  always #50 clk = ~clk;
  dma_channel_select_busy_wrap i_dma_channel_select_busy_wrap (.clk(clk), .reset_n(reset_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .byte_done(byte_done), .chan_active(chan_active), .chan_go(chan_go),
    .full_length_flags(full_length_flags), .mid_point_flags(mid_point_flags),
    .chan_complete(chan_complete));
  dma_sel_datapath_model i_dma_sel_datapath_model (.clk(clk), .reset_n(reset_n),
    .chan_go(chan_go), .gap(gap), .byte_done(byte_done));
  // Compare and count
  task automatic check(input string what, input sfr_byte_t seen, input sfr_byte_t exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One register write
  task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr
  // One register read, data one cycle later
  task automatic rd(input sfr_byte_t a, input sfr_byte_t exp, input string what);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    check(what, sfr_rdata, exp);
  endtask : rd
  // Wait for a channel's completion pulse
  task automatic wait_done(input int ch);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 100 && !seen; i++)
    begin
      @(posedge clk);
      #1;
      seen = chan_complete[ch];
    end
    check("completion", {7'h00, seen}, 8'h01);
  endtask : wait_done
  // Reset values
  task automatic t_reset;
    rd(8'hd1, 8'h00, "select");
    rd(8'hd5, 8'h00, "busy");
    rd(8'hd6, 8'h00, "mode");
  endtask : t_reset
  // Select steering of indirect copies
  task automatic t_select;
    wr(8'hd1, 8'hff);
    rd(8'hd1, 8'h07, "select field");
    for (int c = 0; c < 7; c++)
    begin
      wr(8'hd1, 8'(c));
      wr(8'hce, 8'(c + 16));
    end
    for (int c = 0; c < 7; c++)
    begin
      wr(8'hd1, 8'(c));
      rd(8'hce, 8'(c + 16), "size copy");
    end
    wr(8'hd1, 8'h07);
    wr(8'hce, 8'h55);
    rd(8'hce, 8'h00, "invalid select");
    wr(8'hd1, 8'h00);
    rd(8'hce, 8'h10, "channel 0 kept");
  endtask : t_select
  // Wrap mode per channel
  task automatic t_mode;
    wr(8'hd1, 8'h01);
    wr(8'hd6, 8'hff);
    rd(8'hd6, 8'h01, "mode ch1");
    wr(8'hd1, 8'h02);
    rd(8'hd6, 8'h00, "mode ch2");
    wr(8'hd5, 8'h80);
    rd(8'hd5, 8'h00, "busy bit 7");
  endtask : t_mode
  // Forced start on channel 0, slow datapath, no wrap
  task automatic t_force;
    gap <= 4'h3;
    wr(8'hd1, 8'h00);
    wr(8'hce, 8'h03);
    wr(8'hcf, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hd2, 8'h01);
    wr(8'hd5, 8'h01);
    rd(8'hd5, 8'h01, "busy running");
    check("active pin", {1'b0, chan_active}, 8'h01);
    check("go pin", {1'b0, chan_go}, 8'h01);
    wr(8'hd5, 8'h00);
    wait_done(0);
    check("full pin", {1'b0, full_length_flags}, 8'h01);
    check("mid pin", {1'b0, mid_point_flags}, 8'h01);
    rd(8'hd5, 8'h00, "busy idle");
    rd(8'hd3, 8'h01, "full flag");
    rd(8'hd4, 8'h01, "mid flag");
    rd(8'hcc, 8'h02, "last offset");
  endtask : t_force
  // Wrapping channel 2, prompt datapath, flag clear
  task automatic t_wrap;
    gap <= 4'h0;
    wr(8'hd1, 8'h02);
    wr(8'hce, 8'h04);
    wr(8'hcf, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hd6, 8'h01);
    wr(8'hd2, 8'h04);
    wr(8'hd5, 8'h04);
    wait_done(2);
    rd(8'hcc, 8'h00, "wrapped offset");
    rd(8'hd3, 8'h05, "flags sticky");
    wr(8'hd3, 8'h00);
    rd(8'hd3, 8'h00, "flags cleared");
  endtask : t_wrap
  // Forced start on a disabled channel is lost; stall holds and disable stops a channel
  task automatic t_disabled;
    wr(8'hd2, 8'h00);
    wr(8'hd1, 8'h03);
    wr(8'hce, 8'h02);
    wr(8'hd5, 8'h08);
    rd(8'hd5, 8'h00, "disabled busy");
    check("disabled go pin", {1'b0, chan_go}, 8'h00);
    wr(8'hd1, 8'h04);
    wr(8'hc9, 8'h20);
    wr(8'hd2, 8'h10);
    wr(8'hd5, 8'h10);
    rd(8'hd5, 8'h10, "stalled busy");
    check("stalled go pin", {1'b0, chan_go}, 8'h00);
    wr(8'hc9, 8'h00);
    wr(8'hd2, 8'h00);
    rd(8'hd5, 8'h00, "stopped busy");
    check("stopped active pin", {1'b0, chan_active}, 8'h00);
    rd(8'hd3, 8'h00, "no early flag");
  endtask : t_disabled
  // Reset in mid-run clears select, sticky flags and wrap
  task automatic t_reset_mid;
    rd(8'hd4, 8'h05, "mid before reset");
    wr(8'hd1, 8'h05);
    wr(8'hd6, 8'h01);
    rd(8'hd6, 8'h01, "wrap ch5");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'hd1, 8'h00, "select after reset");
    rd(8'hd4, 8'h00, "mid after reset");
    wr(8'hd1, 8'h05);
    rd(8'hd6, 8'h00, "wrap after reset");
    check("active after reset", {1'b0, chan_active}, 8'h00);
  endtask : t_reset_mid
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_select();
    t_mode();
    t_force();
    t_wrap();
    t_disabled();
    t_reset_mid();
    complete_run();
  end
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule : dma_channel_select_busy_wrap_tb_top
// Checker attached to every design top
bind dma_channel_select_busy_wrap dma_channel_select_busy_wrap_checker #(.NUM_CHAN(NUM_CHAN))
  i_dma_channel_select_busy_wrap_checker (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .byte_done(byte_done), .chan_active(chan_active), .chan_go(chan_go),
  .full_length_flags(full_length_flags), .mid_point_flags(mid_point_flags),
  .chan_complete(chan_complete));
